// ### common/isp_pkg.sv
package isp_pkg;

	// ------------------------------------------------------------
	// Byte addresses and field positions
	// ------------------------------------------------------------
	localparam logic [7:0] ISP_REG_CTRL = 8'hF4;
	localparam logic [7:0] ISP_REG_SAMPLE = 8'hF6;
	localparam int ISP_CTRL_PD_BIT = 0;
	localparam int ISP_CTRL_SETTLED_BIT = 1;
	localparam logic ISP_CTRL_PD_RST = 1'b1;
	localparam logic [7:0] ISP_UNMAPPED_RD = 8'h00;
	localparam int ISP_SAMPLE_W = 8;

	// ------------------------------------------------------------
	// Bus address and timing
	// ------------------------------------------------------------
	localparam logic [6:0] ISP_SLV_ADDR = 7'h00;
	localparam int ISP_CLK_PERIOD_NS = 50;
	localparam int ISP_SETTLE_US = 600;
	localparam int ISP_SETTLE_CYC = (ISP_SETTLE_US * 1000 + ISP_CLK_PERIOD_NS - 1)
		/ ISP_CLK_PERIOD_NS;
	localparam int ISP_SETTLE_W = 14;
	localparam logic [3:0] ISP_BITS_PER_BYTE = 4'h8;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic amp_on;
		logic par_en;
	} isp_cfg_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} isp_i2c_in_t;

	typedef struct packed {
		logic sda_o;
		logic sda_oe;
	} isp_i2c_out_t;

	typedef enum logic [6:0] {
		ISP_ST_IDLE = 7'h01,
		ISP_ST_ADDR = 7'h02,
		ISP_ST_ACK_A = 7'h04,
		ISP_ST_WR = 7'h08,
		ISP_ST_ACK_W = 7'h10,
		ISP_ST_RD = 7'h20,
		ISP_ST_ACK_R = 7'h40
	} isp_state_t;

endpackage

// ### rtl/isp_conv_stage.sv
`timescale 1ns/1ps
module isp_conv_stage (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic conv_done_i,
	input wire logic [isp_pkg::ISP_SAMPLE_W-1:0] conv_data_i,
	input wire logic converter_power_down_i,
	input wire isp_pkg::isp_cfg_t cfg_i,
	output logic [isp_pkg::ISP_SAMPLE_W-1:0] par_o,
	output logic active_o
);

	// ------------------------------------------------------------
	// Capture buffer
	// ------------------------------------------------------------
	logic [isp_pkg::ISP_SAMPLE_W-1:0] buf_r;

	// Idle unless amplifier on, output enabled and not powered down
	assign active_o = cfg_i.amp_on & cfg_i.par_en & ~converter_power_down_i;

	// Done pulse is the only capture event; no other path loads the buffer
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			buf_r <= 8'h00;
		end else if (conv_done_i && active_o) begin
			buf_r <= conv_data_i;
		end
	end

	// Parallel lines held low while output disabled
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			par_o <= 8'h00;
		end else begin
			par_o <= cfg_i.par_en ? buf_r : 8'h00;
		end
	end

endmodule

// ### rtl/isp_adc_i2c_port.sv
`timescale 1ns/1ps
module isp_adc_i2c_port #(
	parameter int SETTLE_CYC = isp_pkg::ISP_SETTLE_CYC
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic conv_done_i,
	input wire logic [isp_pkg::ISP_SAMPLE_W-1:0] conv_data_i,
	input wire isp_pkg::isp_cfg_t cfg_i,
	input wire isp_pkg::isp_i2c_in_t i2c_i,
	output isp_pkg::isp_i2c_out_t i2c_o,
	output logic converter_power_down_o,
	output logic [isp_pkg::ISP_SAMPLE_W-1:0] par_lines_o,
	output logic settled_o
);

	// ------------------------------------------------------------
	// Converter stage
	// ------------------------------------------------------------
	logic conv_active;
	logic [isp_pkg::ISP_SAMPLE_W-1:0] par_lines;
	logic pd_r;

	isp_conv_stage u_conv (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.conv_done_i(conv_done_i),
		.conv_data_i(conv_data_i),
		.converter_power_down_i(pd_r),
		.cfg_i(cfg_i),
		.par_o(par_lines),
		.active_o(conv_active)
	);

	assign par_lines_o = par_lines;
	assign converter_power_down_o = pd_r;

	// ------------------------------------------------------------
	// Line sampling and bus events
	// ------------------------------------------------------------
	logic scl_r;
	logic scl_d_r;
	logic sda_r;
	logic sda_d_r;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;

	// Idle-high reset avoids a false start at release
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			scl_r <= 1'b1;
			scl_d_r <= 1'b1;
			sda_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_r <= i2c_i.scl;
			scl_d_r <= scl_r;
			sda_r <= i2c_i.sda;
			sda_d_r <= sda_r;
		end
	end

	assign scl_rise = scl_r & ~scl_d_r;
	assign scl_fall = ~scl_r & scl_d_r;
	assign start_ev = scl_r & scl_d_r & sda_d_r & ~sda_r;
	assign stop_ev = scl_r & scl_d_r & ~sda_d_r & sda_r;

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	logic [7:0] sample_byte;
	logic [7:0] rd_data;

	// Line n maps to bit n
	for (genvar gi = 0; gi < isp_pkg::ISP_SAMPLE_W; gi++) begin : g_map
		assign sample_byte[gi] = par_lines[gi];
	end

	// ------------------------------------------------------------
	// Protocol engine
	// ------------------------------------------------------------
	isp_pkg::isp_state_t state_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] shift_r;
	logic [7:0] tx_r;
	logic [7:0] ptr_r;
	logic rw_r;
	logic first_wr_r;
	logic mack_r;
	logic sda_oe_r;
	logic ctrl_wr;
	logic byte_done;

	assign byte_done = (bit_cnt_r == isp_pkg::ISP_BITS_PER_BYTE);

	always_comb begin
		if (ptr_r == isp_pkg::ISP_REG_SAMPLE) begin
			rd_data = sample_byte;
		end else if (ptr_r == isp_pkg::ISP_REG_CTRL) begin
			rd_data = 8'h00;
			rd_data[isp_pkg::ISP_CTRL_PD_BIT] = pd_r;
			rd_data[isp_pkg::ISP_CTRL_SETTLED_BIT] = settled_o;
		end else begin
			rd_data = isp_pkg::ISP_UNMAPPED_RD;
		end
	end

	// Data bytes after the pointer byte only land in the control byte
	assign ctrl_wr = (state_r == isp_pkg::ISP_ST_WR) && scl_fall && byte_done
		&& !first_wr_r && (ptr_r == isp_pkg::ISP_REG_CTRL);

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_r <= isp_pkg::ISP_ST_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r <= 8'h00;
			tx_r <= 8'h00;
			ptr_r <= 8'h00;
			rw_r <= 1'b0;
			first_wr_r <= 1'b0;
			mack_r <= 1'b0;
			sda_oe_r <= 1'b0;
		end else if (stop_ev) begin
			state_r <= isp_pkg::ISP_ST_IDLE;
			sda_oe_r <= 1'b0;
		end else if (start_ev) begin
			// Repeated start keeps the pointer
			state_r <= isp_pkg::ISP_ST_ADDR;
			bit_cnt_r <= 4'h0;
			sda_oe_r <= 1'b0;
		end else begin
			case (state_r)
				isp_pkg::ISP_ST_IDLE: begin
					sda_oe_r <= 1'b0;
				end
				isp_pkg::ISP_ST_ADDR, isp_pkg::ISP_ST_WR: begin
					if (scl_rise) begin
						shift_r <= {shift_r[6:0], sda_r};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (scl_fall && byte_done) begin
						if (state_r == isp_pkg::ISP_ST_WR) begin
							sda_oe_r <= 1'b1;
							state_r <= isp_pkg::ISP_ST_ACK_W;
							if (first_wr_r) begin
								ptr_r <= shift_r;
							end
							first_wr_r <= 1'b0;
						end else if (shift_r[7:1] == isp_pkg::ISP_SLV_ADDR) begin
							sda_oe_r <= 1'b1;
							rw_r <= shift_r[0];
							state_r <= isp_pkg::ISP_ST_ACK_A;
						end else begin
							// Other address: stay off the bus until the next start
							state_r <= isp_pkg::ISP_ST_IDLE;
						end
					end
				end
				isp_pkg::ISP_ST_ACK_A: begin
					if (scl_fall) begin
						if (rw_r) begin
							tx_r <= rd_data;
							sda_oe_r <= ~rd_data[7];
							bit_cnt_r <= 4'h1;
							state_r <= isp_pkg::ISP_ST_RD;
						end else begin
							sda_oe_r <= 1'b0;
							bit_cnt_r <= 4'h0;
							first_wr_r <= 1'b1;
							state_r <= isp_pkg::ISP_ST_WR;
						end
					end
				end
				isp_pkg::ISP_ST_ACK_W: begin
					if (scl_fall) begin
						sda_oe_r <= 1'b0;
						bit_cnt_r <= 4'h0;
						state_r <= isp_pkg::ISP_ST_WR;
					end
				end
				isp_pkg::ISP_ST_RD: begin
					if (scl_fall) begin
						if (byte_done) begin
							sda_oe_r <= 1'b0;
							state_r <= isp_pkg::ISP_ST_ACK_R;
						end else begin
							sda_oe_r <= ~tx_r[6];
							tx_r <= {tx_r[6:0], 1'b0};
							bit_cnt_r <= bit_cnt_r + 4'h1;
						end
					end
				end
				isp_pkg::ISP_ST_ACK_R: begin
					if (scl_rise) begin
						mack_r <= ~sda_r;
					end else if (scl_fall) begin
						// No auto-increment: repeated reads fetch fresh lines
						if (mack_r) begin
							tx_r <= rd_data;
							sda_oe_r <= ~rd_data[7];
							bit_cnt_r <= 4'h1;
							state_r <= isp_pkg::ISP_ST_RD;
						end else begin
							state_r <= isp_pkg::ISP_ST_IDLE;
						end
					end
				end
				default: begin
					state_r <= isp_pkg::ISP_ST_IDLE;
					sda_oe_r <= 1'b0;
				end
			endcase
		end
	end

	assign i2c_o.sda_o = 1'b0;
	assign i2c_o.sda_oe = sda_oe_r;

	// ------------------------------------------------------------
	// Control byte
	// ------------------------------------------------------------
	// Powered down from reset so the converter draws nothing until asked
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pd_r <= isp_pkg::ISP_CTRL_PD_RST;
		end else if (ctrl_wr) begin
			pd_r <= shift_r[isp_pkg::ISP_CTRL_PD_BIT];
		end
	end

	// ------------------------------------------------------------
	// Settle timer
	// ------------------------------------------------------------
	logic [isp_pkg::ISP_SETTLE_W-1:0] settle_cnt_r;
	logic settle_hit;

	assign settle_hit = (settle_cnt_r == isp_pkg::ISP_SETTLE_W'(SETTLE_CYC - 1));

	// Status only; the master is still expected to keep its own wait
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			settle_cnt_r <= '0;
			settled_o <= 1'b0;
		end else if (!conv_active) begin
			settle_cnt_r <= '0;
			settled_o <= 1'b0;
		end else if (!settled_o) begin
			settle_cnt_r <= settle_cnt_r + isp_pkg::ISP_SETTLE_W'(1);
			settled_o <= settle_hit;
		end
	end

endmodule

// ### verif/isp_port_asserts.sv
`timescale 1ns/1ps
module isp_port_asserts #(
	parameter int SETTLE_CYC = isp_pkg::ISP_SETTLE_CYC
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic conv_done_i,
	input wire logic [7:0] conv_data_i,
	input wire isp_pkg::isp_cfg_t cfg_i,
	input wire isp_pkg::isp_i2c_in_t i2c_i,
	input wire isp_pkg::isp_i2c_out_t i2c_o,
	input wire logic converter_power_down_o,
	input wire logic [7:0] par_lines_o,
	input wire logic settled_o
);
	// ----
	// Active cycle count
	// ----
	int n_act;
	wire act = cfg_i.amp_on & cfg_i.par_en & ~converter_power_down_o;
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			n_act <= 0;
		else
			n_act <= act ? n_act + 1 : 0;
	end
	// ----
	// Properties
	// ----
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	sequence s_cap; conv_done_i && act ##1 !conv_done_i && cfg_i.par_en; endsequence
	sequence s_idle; cfg_i.par_en && !conv_done_i ##1 cfg_i.par_en; endsequence
	property p_cap; s_cap |=> par_lines_o == $past(conv_data_i, 2); endproperty
	a_cap: assert property (p_cap) else $error("sample not shown");
	property p_hold; s_idle |=> $stable(par_lines_o); endproperty
	a_hold: assert property (p_hold) else $error("lines moved");
	property p_off; !cfg_i.par_en |=> par_lines_o == 8'h00; endproperty
	a_off: assert property (p_off) else $error("lines not cleared");
	property p_unset; converter_power_down_o [*2] |=> !settled_o; endproperty
	a_unset: assert property (p_unset) else $error("settled while down");
	property p_rst; $rose(rstn_i) |-> converter_power_down_o && !settled_o; endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
	property p_pd; $changed(converter_power_down_o) |-> !i2c_i.scl; endproperty
	a_pd: assert property (p_pd) else $error("power line moved off byte end");
	property p_ack; $rose(i2c_o.sda_oe) |-> !i2c_i.scl; endproperty
	a_ack: assert property (p_ack) else $error("data drive while clock high");
	property p_set; $rose(settled_o) |-> n_act == SETTLE_CYC; endproperty
	a_set: assert property (p_set) else $error("settle time wrong");
endmodule

bind isp_adc_i2c_port isp_port_asserts #(.SETTLE_CYC(SETTLE_CYC)) u_chk (
	.clk_i(clk_i), .rstn_i(rstn_i), .conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
	.cfg_i(cfg_i), .i2c_i(i2c_i), .i2c_o(i2c_o), .settled_o(settled_o),
	.converter_power_down_o(converter_power_down_o), .par_lines_o(par_lines_o)
);

// ### verif/isp_i2c_master.sv
`timescale 1ns/1ps
module isp_i2c_master #(
	parameter int HALF = 6,
	parameter int WAIT = 24
) (
	input wire logic clk_i,
	input wire isp_pkg::isp_i2c_out_t drv_i,
	output isp_pkg::isp_i2c_in_t bus_o
);
	// ----
	// Bus phases
	// ----
	logic scl = 1'b1;
	logic sdm = 1'b1;
	// Pull-up: wire is low only if someone pulls
	assign bus_o = {scl, sdm & ~(drv_i.sda_oe & ~drv_i.sda_o)};
	task automatic hp();
		repeat (HALF) @(posedge clk_i);
		#1;
	endtask
	task automatic bt(input logic b, output logic r);
		// One edge gap so data never moves with the clock fall
		@(posedge clk_i);
		#1;
		sdm = b;
		hp();
		scl = 1'b1;
		hp();
		r = bus_o.sda;
		scl = 1'b0;
	endtask
	task automatic xb(input logic [7:0] o, output logic [7:0] d, output logic a);
		for (int i = 7; i >= 0; i--) bt(o[i], d[i]);
		bt(1'b1, a);
	endtask
	task automatic st();
		hp();
		sdm = 1'b1;
		hp();
		scl = 1'b1;
		hp();
		sdm = 1'b0;
		hp();
		scl = 1'b0;
	endtask
	task automatic sp();
		hp();
		sdm = 1'b0;
		hp();
		scl = 1'b1;
		hp();
		sdm = 1'b1;
		hp();
	endtask
	task automatic wr(input logic [6:0] sa, input logic [7:0] p, v, output logic a);
		logic [7:0] d;
		logic a1, a2, a3;
		st();
		xb({sa, 1'b0}, d, a1);
		xb(p, d, a2);
		xb(v, d, a3);
		sp();
		a = a1 | a2 | a3;
	endtask
	task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic a);
		logic a1, a2, a3, n;
		st();
		xb({isp_pkg::ISP_SLV_ADDR, 1'b0}, d, a1);
		xb(p, d, a2);
		st();
		xb({isp_pkg::ISP_SLV_ADDR, 1'b1}, d, a3);
		xb(8'hFF, d, n);
		sp();
		a = a1 | a2 | a3;
	endtask
	// Two bytes: master acks the first so the slave fetches again
	task automatic rd2(input logic [7:0] p, output logic [7:0] d0, d1, output logic a);
		logic [7:0] d;
		logic a1, a2, a3, a4, n;
		st();
		xb({isp_pkg::ISP_SLV_ADDR, 1'b0}, d, a1);
		xb(p, d, a2);
		st();
		xb({isp_pkg::ISP_SLV_ADDR, 1'b1}, d, a3);
		for (int i = 7; i >= 0; i--) bt(1'b1, d0[i]);
		bt(1'b0, a4);
		xb(8'hFF, d1, n);
		sp();
		a = a1 | a2 | a3 | a4;
	endtask
	task automatic settle();
		repeat (WAIT) @(posedge clk_i);
		#1;
	endtask
endmodule

// ### verif/tb_isp_adc_i2c_port.sv
`timescale 1ns/1ps
module tb_isp_adc_i2c_port;
	localparam int SET = 20;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic conv_done_i = 1'b0;
	logic [7:0] conv_data_i = 8'h00;
	isp_pkg::isp_cfg_t cfg_i = 2'h3;
	isp_pkg::isp_i2c_in_t i2c_i;
	isp_pkg::isp_i2c_out_t i2c_o;
	logic pd, st, a;
	logic [7:0] par, d, d2, v;
	int n_mismatch = 0;
	int n_checks = 0;
	int cyc = 0;
	initial begin
		forever #25 clk_i = ~clk_i;
	end
	isp_adc_i2c_port #(.SETTLE_CYC(SET)) dut (
		.clk_i(clk_i), .rstn_i(rstn_i), .conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
		.cfg_i(cfg_i), .i2c_i(i2c_i), .i2c_o(i2c_o), .converter_power_down_o(pd),
		.par_lines_o(par), .settled_o(st)
	);
	isp_i2c_master #(.WAIT(SET + 4)) m (.clk_i(clk_i), .drv_i(i2c_o), .bus_o(i2c_i));
	// ----
	// Tasks
	// ----
	task automatic chk(input logic [7:0] s, e);
		n_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h, want %h", $time, s, e);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic conv(input logic [7:0] x);
		conv_data_i = x;
		conv_done_i = 1'b1;
		step(1);
		conv_done_i = 1'b0;
		step(3);
	endtask
	task automatic results();
		$display("checks %0d, mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Hang guard, well above the run length
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			results();
		end
	end
	// ----
	// Sequence
	// ----
	initial begin
		step(3);
		rstn_i = 1'b1;
		chk(pd, 1'b1);
		step(2);
		m.wr(7'h00, isp_pkg::ISP_REG_CTRL, 8'h00, a);
		chk(a, 1'b0);
		chk(pd, 1'b0);
		m.settle();
		chk(st, 1'b1);
		m.rd(isp_pkg::ISP_REG_CTRL, d, a);
		chk(d, 8'h02);
		$display("enable done");
		for (int i = 0; i < 9; i++) begin
			v = (i < 8) ? 8'h01 << i : 8'hA5;
			conv(v);
			chk(par, v);
			m.rd(isp_pkg::ISP_REG_SAMPLE, d, a);
			chk(d, v);
			chk(a, 1'b0);
		end
		conv_data_i = 8'h3C;
		step(4);
		chk(par, 8'hA5);
		m.rd2(isp_pkg::ISP_REG_SAMPLE, d, d2, a);
		chk(d, 8'hA5);
		chk(d2, 8'hA5);
		chk(a, 1'b0);
		cfg_i.amp_on = 1'b0;
		conv(8'h3C);
		chk(par, 8'hA5);
		chk(st, 1'b0);
		cfg_i.amp_on = 1'b1;
		$display("sample reads done");
		m.wr(7'h00, isp_pkg::ISP_REG_CTRL, 8'h01, a);
		chk(pd, 1'b1);
		chk(st, 1'b0);
		m.wr(7'h00, 8'h10, 8'h00, a);
		chk(a, 1'b0);
		chk(pd, 1'b1);
		conv(8'h3C);
		chk(par, 8'hA5);
		m.wr(7'h01, isp_pkg::ISP_REG_CTRL, 8'h00, a);
		chk(a, 1'b1);
		chk(pd, 1'b1);
		m.rd(8'h10, d, a);
		chk(d, isp_pkg::ISP_UNMAPPED_RD);
		$display("power down done");
		cfg_i.par_en = 1'b0;
		step(2);
		chk(par, 8'h00);
		m.wr(7'h00, isp_pkg::ISP_REG_CTRL, 8'h00, a);
		chk(pd, 1'b0);
		chk(st, 1'b0);
		rstn_i = 1'b0;
		step(1);
		rstn_i = 1'b1;
		chk(pd, 1'b1);
		m.rd(isp_pkg::ISP_REG_CTRL, d, a);
		chk(d, 8'h01);
		chk(a, 1'b0);
		$display("disable done");
		results();
	end
endmodule
